// ===== inc/rhd_pkg.sv
// Package with register map, field positions and reset values of the root hub descriptor block
package rhd_pkg;

  // Register byte offsets
  localparam logic [3:0] RHD_OFS_DESC_A     = 4'h0;  // First descriptor
  localparam logic [3:0] RHD_OFS_DESC_B     = 4'h4;  // Port power control mask
  localparam logic [3:0] RHD_OFS_POWER_CMD  = 4'h8;  // Power commands, write only
  localparam logic [3:0] RHD_OFS_POWER_STAT = 4'hC;  // Port power state, read only

  // Geometry
  localparam int         RHD_PORTS      = 2;         // Downstream ports
  localparam int         RHD_ADDR_W     = 4;         // Byte address width
  localparam int         RHD_DATA_W     = 32;        // Bus data width
  localparam int         RHD_BE_W       = 4;         // Byte enables

  // First descriptor field positions
  localparam int         RHD_POTPG_LSB  = 24;        // Power good delay, bits 31..24
  localparam int         RHD_POTPG_MSB  = 31;
  localparam int         RHD_NOOC_BIT   = 12;        // No overcurrent protection
  localparam int         RHD_OCM_BIT    = 11;        // Overcurrent mode
  localparam int         RHD_CMPD_BIT   = 10;        // Compound device flag
  localparam int         RHD_NOSW_BIT   = 9;         // No power switching
  localparam int         RHD_SWMODE_BIT = 8;         // Power switching mode
  localparam int         RHD_PCNT_LSB   = 0;         // Port count, bits 1..0
  localparam int         RHD_PCNT_MSB   = 1;

  // Second descriptor mask field, bit 16 reserved, bits 18..17 ports 1..2
  localparam int         RHD_PMASK_LSB  = 17;
  localparam int         RHD_PMASK_MSB  = 18;

  // Power command bit positions
  localparam int         RHD_CMD_GSET   = 0;         // Set global power
  localparam int         RHD_CMD_GCLR   = 1;         // Clear global power
  localparam int         RHD_CMD_PSET   = 9;         // Per-port set, bits 10..9
  localparam int         RHD_CMD_PCLR   = 17;        // Per-port clear, bits 18..17
  localparam int         RHD_STAT_LSB   = 1;         // Port power state, bits 2..1

  // Byte lanes of the fields above
  localparam int         RHD_LANE_TOP   = 3;         // Power good delay
  localparam int         RHD_LANE_MODE  = 1;         // Mode bits 12..8
  localparam int         RHD_LANE_MASK  = 2;         // Mask bits 18..17
  localparam int         RHD_LANE_LOW   = 0;         // Global commands
  localparam int         RHD_LANE_PCLR  = 2;         // Per-port clear
  localparam int         RHD_LANE_PSET  = 1;         // Per-port set

  // Default reset values, implementation specific
  localparam logic [7:0] RHD_RST_POTPG  = 8'h01;
  localparam logic       RHD_RST_NOOC   = 1'h0;
  localparam logic       RHD_RST_NOSW   = 1'h0;
  localparam logic       RHD_RST_SWMODE = 1'h1;
  localparam logic [1:0] RHD_RST_PMASK  = 2'h0;
  localparam logic [1:0] RHD_PCNT_VALUE = 2'h2;      // Port count reported
  localparam logic       RHD_CMPD_VALUE = 1'h0;      // Never compound

  // Bus handshake phase
  typedef enum logic [0:0]
  {
    RHD_PH_IDLE = 1'b0,                              // Waiting or first request cycle
    RHD_PH_ACK  = 1'b1                               // Answer cycle
  } rhd_phase_type;

endpackage

// ===== logic/rhd_port_power.sv
// Power state of one root hub port under global and per-port commands
`timescale 1ns/1ps
module rhd_port_power
  import rhd_pkg::*;
(
  input  wire logic i_mclk,          // Controller clock
  input  wire logic i_nrst,          // Synchronous reset, active low
  input  wire logic i_no_switching,  // Ports always powered
  input  wire logic i_per_port_mode, // Individual switching mode
  input  wire logic i_mask,          // Port answers per-port commands only in individual switching mode
  input  wire logic i_global_set,    // Global set pulse
  input  wire logic i_global_clear,  // Global clear pulse
  input  wire logic i_port_set,      // Per-port set pulse
  input  wire logic i_port_clear,    // Per-port clear pulse
  output logic      o_power          // Port powered
);

  logic power;       // Current state
  logic next_power;  // Next state

  // Select command source; set wins over clear when both arrive together
  always_comb
  begin
    next_power = power;
    if (i_no_switching)
    begin
      // Always powered while the controller is powered
      next_power = 1'b1;
    end
    else if (i_per_port_mode && i_mask)
    begin
      // Only per-port commands reach this port
      if (i_port_set)
        next_power = 1'b1;
      else if (i_port_clear)
        next_power = 1'b0;
    end
    else
    begin
      // Ganged mode or unmasked port: global commands only
      if (i_global_set)
        next_power = 1'b1;
      else if (i_global_clear)
        next_power = 1'b0;
    end
  end

  // State register
  always_ff @(posedge i_mclk)
  begin
    if (!i_nrst)
      power <= 1'b0;
    else
      power <= next_power;
  end

  assign o_power = power;

endmodule

// ===== logic/rhd_root_hub_descriptor.sv
// Root hub descriptor A and B register bank with Avalon-MM slave and port power control
`timescale 1ns/1ps
module rhd_root_hub_descriptor
  import rhd_pkg::*;
#(
  parameter logic [7:0] RST_POWER_GOOD_DELAY = RHD_RST_POTPG, // Reset delay value
  parameter logic       RST_NO_OC_PROTECT    = RHD_RST_NOOC,   // Reset no-protection
  parameter logic       RST_NO_SWITCHING     = RHD_RST_NOSW,   // Reset always-powered
  parameter logic       RST_SWITCHING_MODE   = RHD_RST_SWMODE, // Reset switching mode
  parameter logic [1:0] RST_POWER_MASK       = RHD_RST_PMASK   // Reset port mask
)
(
  input  wire logic                  i_mclk,                 // Controller clock
  input  wire logic                  i_nrst,                 // Synchronous reset, low
  input  wire logic [RHD_ADDR_W-1:0] i_avs_address,          // Byte address
  input  wire logic                  i_avs_read,             // Read request
  input  wire logic                  i_avs_write,            // Write request
  input  wire logic [RHD_DATA_W-1:0] i_avs_writedata,        // Write data
  input  wire logic [RHD_BE_W-1:0]   i_avs_byteenable,       // Byte lanes
  output logic [RHD_DATA_W-1:0]      o_avs_readdata,         // Read data, registered
  output logic                       o_avs_waitrequest,      // Stall
  output logic [7:0]                 o_power_good_delay,     // Delay in 2 ms units
  output logic                       o_overcurrent_global,   // Collective reporting
  output logic                       o_overcurrent_per_port, // Per-port reporting
  output logic [RHD_PORTS-1:0]       o_port_power            // Port power enables
);

  // Descriptor A state and descriptor B mask
  logic [7:0]            power_good_delay;            // Delay field
  logic                  no_overcurrent_protect;      // No reporting
  logic                  overcurrent_mode;            // Per-port reporting select
  logic                  no_power_switching;          // Always powered
  logic                  power_switching_mode;        // Individual switching
  logic [RHD_PORTS-1:0]  port_power_control_mask;     // Per-port mask
  logic [7:0]            next_power_good_delay;
  logic                  next_no_overcurrent_protect;
  logic                  next_overcurrent_mode;
  logic                  next_no_power_switching;
  logic                  next_power_switching_mode;
  logic [RHD_PORTS-1:0]  next_port_power_control_mask;

  // Decoded overcurrent outputs
  logic                  oc_global;
  logic                  oc_per_port;
  logic                  next_oc_global;
  logic                  next_oc_per_port;

  // Bus state
  rhd_phase_type         phase;                       // Handshake phase
  rhd_phase_type         next_phase;
  logic [RHD_DATA_W-1:0] readdata;                    // Registered answer
  logic [RHD_DATA_W-1:0] next_readdata;
  logic                  request;                     // Read or write present
  logic                  commit;                      // Cycle that completes it
  logic                  write_commit;                // Write takes effect now

  // Command pulses, one cycle, to the port slices
  logic                  global_set;
  logic                  global_clear;
  logic [RHD_PORTS-1:0]  port_set;
  logic [RHD_PORTS-1:0]  port_clear;
  logic [RHD_PORTS-1:0]  port_power;                  // Slice outputs

  // Handshake: one wait cycle, then the answer
  assign request           = i_avs_read | i_avs_write;
  assign commit            = request & (phase == RHD_PH_ACK);
  assign write_commit      = commit & i_avs_write;
  assign o_avs_waitrequest = request & (phase == RHD_PH_IDLE);

  // Next phase and read data
  always_comb
  begin
    next_phase    = RHD_PH_IDLE;
    next_readdata = readdata;
    if (request && (phase == RHD_PH_IDLE))
    begin
      // Capture the answer so it stands on the completing edge
      next_phase    = RHD_PH_ACK;
      next_readdata = '0;
      if (i_avs_read)
      begin
        unique case (i_avs_address)
          RHD_OFS_DESC_A:
          begin
            next_readdata[RHD_POTPG_MSB:RHD_POTPG_LSB] = power_good_delay;
            next_readdata[RHD_NOOC_BIT]   = no_overcurrent_protect;
            next_readdata[RHD_OCM_BIT]    = overcurrent_mode;
            next_readdata[RHD_CMPD_BIT]   = RHD_CMPD_VALUE;
            next_readdata[RHD_NOSW_BIT]   = no_power_switching;
            next_readdata[RHD_SWMODE_BIT] = power_switching_mode;
            next_readdata[RHD_PCNT_MSB:RHD_PCNT_LSB] = RHD_PCNT_VALUE;
          end
          RHD_OFS_DESC_B:
          begin
            // Bit 16 stays zero as reserved
            next_readdata[RHD_PMASK_MSB:RHD_PMASK_LSB] = port_power_control_mask;
          end
          RHD_OFS_POWER_STAT:
          begin
            next_readdata[RHD_STAT_LSB +: RHD_PORTS] = port_power;
          end
          default:
          begin
            // Command register and unmapped offsets read as zero
            next_readdata = '0;
          end
        endcase
      end
    end
  end

  // Bus registers
  always_ff @(posedge i_mclk)
  begin
    if (!i_nrst)
    begin
      phase    <= RHD_PH_IDLE;
      readdata <= '0;
    end
    else
    begin
      phase    <= next_phase;
      readdata <= next_readdata;
    end
  end

  assign o_avs_readdata = readdata;

  // Command pulses decoded from a completing write to the command offset
  always_comb
  begin
    global_set   = 1'b0;
    global_clear = 1'b0;
    port_set     = '0;
    port_clear   = '0;
    if (write_commit && (i_avs_address == RHD_OFS_POWER_CMD))
    begin
      if (i_avs_byteenable[RHD_LANE_LOW])
      begin
        global_set   = i_avs_writedata[RHD_CMD_GSET];
        global_clear = i_avs_writedata[RHD_CMD_GCLR];
      end
      if (i_avs_byteenable[RHD_LANE_PSET])
        port_set   = i_avs_writedata[RHD_CMD_PSET +: RHD_PORTS];
      if (i_avs_byteenable[RHD_LANE_PCLR])
        port_clear = i_avs_writedata[RHD_CMD_PCLR +: RHD_PORTS];
    end
  end

  // Next descriptor values from completing writes
  always_comb
  begin
    next_power_good_delay        = power_good_delay;
    next_no_overcurrent_protect  = no_overcurrent_protect;
    next_overcurrent_mode        = overcurrent_mode;
    next_no_power_switching      = no_power_switching;
    next_power_switching_mode    = power_switching_mode;
    next_port_power_control_mask = port_power_control_mask;
    if (write_commit && (i_avs_address == RHD_OFS_DESC_A))
    begin
      if (i_avs_byteenable[RHD_LANE_TOP])
        next_power_good_delay = i_avs_writedata[RHD_POTPG_MSB:RHD_POTPG_LSB];
      if (i_avs_byteenable[RHD_LANE_MODE])
      begin
        // Compound flag has no storage, so a write cannot change it
        next_no_overcurrent_protect = i_avs_writedata[RHD_NOOC_BIT];
        // Software may clear then set this bit at power-up
        next_overcurrent_mode       = i_avs_writedata[RHD_OCM_BIT];
        next_no_power_switching     = i_avs_writedata[RHD_NOSW_BIT];
        next_power_switching_mode   = i_avs_writedata[RHD_SWMODE_BIT];
      end
      // Port count and reserved bits are not stored
    end
    if (write_commit && (i_avs_address == RHD_OFS_DESC_B))
    begin
      if (i_avs_byteenable[RHD_LANE_MASK])
        next_port_power_control_mask =
          i_avs_writedata[RHD_PMASK_MSB:RHD_PMASK_LSB];
    end
  end

  // Decoded overcurrent reporting; mode bit ignored when protection is absent
  always_comb
  begin
    next_oc_global   = ~next_no_overcurrent_protect & ~next_overcurrent_mode;
    next_oc_per_port = ~next_no_overcurrent_protect &  next_overcurrent_mode;
  end

  // Descriptor registers
  always_ff @(posedge i_mclk)
  begin
    if (!i_nrst)
    begin
      power_good_delay        <= RST_POWER_GOOD_DELAY;
      no_overcurrent_protect  <= RST_NO_OC_PROTECT;
      // Overcurrent mode starts equal to the switching mode
      overcurrent_mode        <= RST_SWITCHING_MODE;
      no_power_switching      <= RST_NO_SWITCHING;
      power_switching_mode    <= RST_SWITCHING_MODE;
      port_power_control_mask <= RST_POWER_MASK;
      oc_global               <= ~RST_NO_OC_PROTECT & ~RST_SWITCHING_MODE;
      oc_per_port             <= ~RST_NO_OC_PROTECT &  RST_SWITCHING_MODE;
    end
    else
    begin
      power_good_delay        <= next_power_good_delay;
      no_overcurrent_protect  <= next_no_overcurrent_protect;
      overcurrent_mode        <= next_overcurrent_mode;
      no_power_switching      <= next_no_power_switching;
      power_switching_mode    <= next_power_switching_mode;
      port_power_control_mask <= next_port_power_control_mask;
      oc_global               <= next_oc_global;
      oc_per_port             <= next_oc_per_port;
    end
  end

  // One power slice per port; mode bits only matter when switching exists
  genvar gi;
  generate
    for (gi = 0; gi < RHD_PORTS; gi++)
    begin : g_port
      rhd_port_power u_power
      (
        .i_mclk          (i_mclk),
        .i_nrst          (i_nrst),
        .i_no_switching  (no_power_switching),
        .i_per_port_mode (power_switching_mode),
        .i_mask          (port_power_control_mask[gi]),
        .i_global_set    (global_set),
        .i_global_clear  (global_clear),
        .i_port_set      (port_set[gi]),
        .i_port_clear    (port_clear[gi]),
        .o_power         (port_power[gi])
      );
    end
  endgenerate

  // Outputs straight from registers
  assign o_power_good_delay     = power_good_delay;
  assign o_overcurrent_global   = oc_global;
  assign o_overcurrent_per_port = oc_per_port;
  assign o_port_power           = port_power;

endmodule

// ===== bench/rhd_monitor.sv
// Checker of the root hub descriptor block, bound to its top module ports
`timescale 1ns/1ps
module rhd_monitor
  import rhd_pkg::*;
#(
  parameter logic RST_NO_OC_PROTECT  = RHD_RST_NOOC,  // Reset no-protection
  parameter logic RST_SWITCHING_MODE = RHD_RST_SWMODE // Reset switching mode
)
(
  input wire logic                  i_mclk,                 // Controller clock
  input wire logic                  i_nrst,                 // Synchronous reset, low
  input wire logic [RHD_ADDR_W-1:0] i_avs_address,          // Byte address
  input wire logic                  i_avs_read,             // Read request
  input wire logic                  i_avs_write,            // Write request
  input wire logic [RHD_DATA_W-1:0] i_avs_writedata,        // Write data
  input wire logic [RHD_BE_W-1:0]   i_avs_byteenable,       // Byte lanes
  input wire logic [RHD_DATA_W-1:0] o_avs_readdata,         // Read data
  input wire logic                  o_avs_waitrequest,      // Stall
  input wire logic [7:0]            o_power_good_delay,     // Delay copy
  input wire logic                  o_overcurrent_global,   // Collective reporting
  input wire logic                  o_overcurrent_per_port, // Per-port reporting
  input wire logic [RHD_PORTS-1:0]  o_port_power            // Port power
);
  // Transfers seen at their answering edge only
  wire logic rd_a  = i_avs_read && !o_avs_waitrequest && i_avs_address == RHD_OFS_DESC_A;
  wire logic rd_b  = i_avs_read && !o_avs_waitrequest && i_avs_address == RHD_OFS_DESC_B;
  wire logic wr_a  = i_avs_write && !o_avs_waitrequest && i_avs_address == RHD_OFS_DESC_A;
  wire logic wr_md = wr_a && i_avs_byteenable[RHD_LANE_MODE]; // Mode lane written

  // One clock domain, so one default clock and disable
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_nrst);

  wait_first_a: assert property ((i_avs_read || i_avs_write) && o_avs_waitrequest
    |=> !o_avs_waitrequest) else $error("no answer one cycle after request");
  idle_nowait_a: assert property (!(i_avs_read || i_avs_write) |-> !o_avs_waitrequest)
    else $error("stall without request");
  delay_write_a: assert property (wr_a && i_avs_byteenable[RHD_LANE_TOP]
    |=> o_power_good_delay == $past(i_avs_writedata[31:24])) else $error("delay not stored");
  delay_read_a: assert property (rd_a |-> o_avs_readdata[31:24] == o_power_good_delay)
    else $error("delay readback differs");
  oc_none_a: assert property (wr_md && i_avs_writedata[12]
    |=> !o_overcurrent_global && !o_overcurrent_per_port) else $error("reporting while none");
  oc_mode_a: assert property (wr_md && !i_avs_writedata[12]
    |=> o_overcurrent_per_port == $past(i_avs_writedata[11])
    && o_overcurrent_global == !$past(i_avs_writedata[11])) else $error("wrong reporting mode");
  oc_reset_a: assert property ($past(!i_nrst)
    |-> o_overcurrent_per_port == (!RST_NO_OC_PROTECT && RST_SWITCHING_MODE)
    && o_overcurrent_global == (!RST_NO_OC_PROTECT && !RST_SWITCHING_MODE))
    else $error("reset mode mismatch");
  compound_zero_a: assert property (rd_a |-> !o_avs_readdata[10])
    else $error("compound flag set");
  nps_power_a: assert property (wr_md && i_avs_writedata[9]
    |=> ##[0:1] o_port_power == 2'h3) else $error("ports not always powered");
  port_count_a: assert property (rd_a |-> o_avs_readdata[1:0] == 2'h2)
    else $error("wrong port count");
  mask_reserved_a: assert property (rd_b
    |-> !o_avs_readdata[16] && o_avs_readdata[31:19] == 13'h0000) else $error("mask spare set");
  reserved_zero_a: assert property (rd_a
    |-> o_avs_readdata[23:13] == 11'h000 && o_avs_readdata[7:2] == 6'h00)
    else $error("reserved bits set");
endmodule

bind rhd_root_hub_descriptor rhd_monitor #(
  .RST_NO_OC_PROTECT (RST_NO_OC_PROTECT),
  .RST_SWITCHING_MODE(RST_SWITCHING_MODE)
) u_mon (
  .i_mclk                 (i_mclk),
  .i_nrst                 (i_nrst),
  .i_avs_address          (i_avs_address),
  .i_avs_read             (i_avs_read),
  .i_avs_write            (i_avs_write),
  .i_avs_writedata        (i_avs_writedata),
  .i_avs_byteenable       (i_avs_byteenable),
  .o_avs_readdata         (o_avs_readdata),
  .o_avs_waitrequest      (o_avs_waitrequest),
  .o_power_good_delay     (o_power_good_delay),
  .o_overcurrent_global   (o_overcurrent_global),
  .o_overcurrent_per_port (o_overcurrent_per_port),
  .o_port_power           (o_port_power)
);

// ===== bench/tb_top.sv
// Register access testbench of the root hub descriptor block
`timescale 1ns/1ps
`define CHK(got, exp) \
  begin n_checks++; if ((got) !== (exp)) begin fail_count++; \
  $display("unexpected at %0t: got %h want %h", $time, got, exp); end end
module tb_top
  import rhd_pkg::*;
;
  logic        i_mclk = 1'b0;   // Bench clock
  logic        i_nrst = 1'b0;   // Reset, active low
  logic [3:0]  addr   = 4'h0;   // Bus address
  logic        rd     = 1'b0;   // Read request
  logic        wr     = 1'b0;   // Write request
  logic [31:0] wdata  = 32'h0;  // Write data
  logic [3:0]  be     = 4'h0;   // Byte lanes
  logic [31:0] rdata;           // Read data
  logic        wait_rq;         // Stall
  logic [7:0]  pgd;             // Delay copy
  logic        ocg;             // Collective reporting
  logic        ocp;             // Per-port reporting
  logic [1:0]  pwr_on;          // Port power
  int          fail_count = 0;  // Mismatches
  int          n_checks   = 0;  // Comparisons
  int          cycles     = 0;  // Timeout counter
  // Reset image built from the package defaults
  logic [31:0] rst_a = {RHD_RST_POTPG, 11'h000, RHD_RST_NOOC, RHD_RST_SWMODE, 1'b0,
                        RHD_RST_NOSW, RHD_RST_SWMODE, 6'h00, RHD_PCNT_VALUE};

  rhd_root_hub_descriptor dut (
    .i_mclk(i_mclk), .i_nrst(i_nrst), .i_avs_address(addr), .i_avs_read(rd),
    .i_avs_write(wr), .i_avs_writedata(wdata), .i_avs_byteenable(be),
    .o_avs_readdata(rdata), .o_avs_waitrequest(wait_rq), .o_power_good_delay(pgd),
    .o_overcurrent_global(ocg), .o_overcurrent_per_port(ocp), .o_port_power(pwr_on)
  );

  // Free running 100 MHz clock
  always #5 i_mclk = ~i_mclk;

  // Verdict and end of run
  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // Hang guard, far above the hundred or so cycles the sequence needs
  always @(posedge i_mclk)
  begin
    cycles <= cycles + 1;
    if (cycles == 3000)
    begin
      fail_count++;
      complete_run();
    end
  end

  // One bus cycle; held until the rising edge that samples the stall low
  task automatic xfer(input logic w, input logic [3:0] a, input logic [31:0] d,
                      input logic [3:0] e, output logic [31:0] q);
    @(posedge i_mclk);
    rd <= !w;
    wr <= w;
    addr <= a;
    wdata <= d;
    be <= e;
    // Values seen here are those before the edge; only the hang guard ends a wait
    do
    begin
      @(posedge i_mclk);
    end
    while (wait_rq !== 1'b0);
    // Answer edge: read data taken here, then the request is dropped
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask

  task automatic wrt(input logic [3:0] a, input logic [31:0] d, input logic [3:0] e);
    logic [31:0] q;
    xfer(1'b1, a, d, e, q);
  endtask

  task automatic rdc(input logic [3:0] a, input logic [31:0] exp);
    logic [31:0] q;
    xfer(1'b0, a, 32'h0000_0000, 4'hF, q);
    `CHK(q, exp)
  endtask

  // Outputs looked at once the completing edge has landed
  task automatic oc(input logic [1:0] exp);
    @(negedge i_mclk);
    `CHK({ocg, ocp}, exp)
  endtask

  task automatic pwr(input logic [1:0] exp);
    @(negedge i_mclk);
    @(negedge i_mclk);
    `CHK(pwr_on, exp)
  endtask

  // Main sequence
  initial
  begin
    repeat (12) @(posedge i_mclk);
    i_nrst <= 1'b1;
    rdc(RHD_OFS_DESC_A, rst_a);
    `CHK(ocp, 1'b1)
    rdc(RHD_OFS_DESC_B, 32'h0000_0000);
    rdc(RHD_OFS_POWER_STAT, 32'h0000_0000);
    rdc(4'h1, 32'h0000_0000);
    // All ones: reserved and compound stay clear, ports forced on
    wrt(RHD_OFS_DESC_A, 32'hFFFF_FFFF, 4'hF);
    rdc(RHD_OFS_DESC_A, 32'hFF00_1B02);
    `CHK(pgd, 8'hFF)
    oc(2'b00);
    pwr(2'h3);
    // Port count ignores writes to the low lane
    wrt(RHD_OFS_DESC_A, 32'h0000_0000, 4'h3);
    rdc(RHD_OFS_DESC_A, 32'hFF00_0002);
    oc(2'b10);
    wrt(RHD_OFS_DESC_A, 32'h0000_0800, 4'h2);
    oc(2'b01);
    wrt(RHD_OFS_DESC_A, 32'h0000_1800, 4'h2);
    oc(2'b00);
    // Ganged switching: only global commands act
    wrt(RHD_OFS_POWER_CMD, 32'h0000_0001, 4'h1);
    pwr(2'h3);
    wrt(RHD_OFS_POWER_CMD, 32'h0000_0002, 4'h1);
    pwr(2'h0);
    wrt(RHD_OFS_POWER_CMD, 32'h0000_0600, 4'h2);
    pwr(2'h0);
    // Individual switching, port 1 masked
    wrt(RHD_OFS_DESC_A, 32'h0000_0100, 4'h2);
    wrt(RHD_OFS_DESC_B, 32'h0002_0000, 4'h4);
    wrt(RHD_OFS_POWER_CMD, 32'h0000_0001, 4'h1);
    pwr(2'h2);
    wrt(RHD_OFS_POWER_CMD, 32'h0000_0200, 4'h2);
    pwr(2'h3);
    wrt(RHD_OFS_POWER_CMD, 32'h0000_0002, 4'h1);
    pwr(2'h1);
    rdc(RHD_OFS_POWER_STAT, 32'h0000_0002);
    wrt(RHD_OFS_POWER_CMD, 32'h0000_0400, 4'h2);
    pwr(2'h1);
    wrt(RHD_OFS_POWER_CMD, 32'h0002_0000, 4'h4);
    pwr(2'h0);
    // Spare bits of the mask word and the command word read zero
    wrt(RHD_OFS_DESC_B, 32'hFFFF_FFFF, 4'hF);
    rdc(RHD_OFS_DESC_B, 32'h0006_0000);
    rdc(RHD_OFS_POWER_CMD, 32'h0000_0000);
    // Delay byte alone
    wrt(RHD_OFS_DESC_A, 32'h5A00_0000, 4'h8);
    rdc(RHD_OFS_DESC_A, 32'h5A00_0102);
    complete_run();
  end
endmodule
